// ===== tvp_pwm_bank.sv
// eight six bit pwm dacs and one fourteen bit pwm dac with pin takeover
`timescale 1ns/1ps
`default_nettype none
module tvp_pwm_bank
	import tvp_pkg::*;
#(
	parameter int CORE_KHZ = TVP_CORE_KHZ
)
(
	input  wire logic       core_clk_in,
	input  wire logic       rst_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	output logic      [7:0] sfr_rdata_out,
	input  wire logic [7:0] port2_latch_in,
	input  wire logic       port3_bit4_latch_in,
	output logic      [7:0] port2_pin_out,
	output logic            port3_bit4_pin_out
);
	// clock divider: core cycles per step, step = four oscillator periods
	localparam int STEP_DIV = (CORE_KHZ * TVP_STEP_OSC) / TVP_OSC_KHZ;
	localparam logic [7:0] STEP_LAST = 8'(STEP_DIV - 1);

	initial
	begin
		if (STEP_DIV < 1 || STEP_DIV > 256)
			$error("core clock rate cannot make the pwm step");
	end

	logic [7:0] div_ff;
	logic       step_en_ff;
	logic [6:0] step_ff;
	logic [6:0] frame_ff;
	logic [7:0] duty_reg_ff [8];
	logic [7:0] fine_low_ff;
	logic [7:0] fine_high_ff;
	logic [13:0] fine_act_ff;
	logic       fine_en_ff;
	logic       fine_pwm_ff;
	logic [7:0] p2_ff;
	logic       p34_ff;
	logic [7:0] rdata_ff;

	logic [7:0] nxt_div;
	logic       nxt_step_en;
	logic [7:0] chan_pwm;
	logic [7:0] wr_duty;
	logic       wr_low;
	logic       wr_high;
	logic       period64;
	logic       period128;
	logic [6:0] nxt_step;
	logic [6:0] base_w;
	logic [6:0] ext_n;
	logic       ext_now;
	logic [6:0] rev_frame;
	logic       nxt_fine_pwm;
	logic [7:0] nxt_p2;
	logic       nxt_p34;
	logic [7:0] nxt_rdata;
	logic [7:0] duty_sel;
	logic       duty_hit;

	localparam logic [7:0] DUTY_ADDR [8] = '{TVP_ADDR_DUTY0,
		TVP_ADDR_DUTY1, TVP_ADDR_DUTY2, TVP_ADDR_DUTY3, TVP_ADDR_DUTY4,
		TVP_ADDR_DUTY5, TVP_ADDR_DUTY6, TVP_ADDR_DUTY7};

	// step enable from core clock divider
	assign nxt_div     = (div_ff == STEP_LAST) ? 8'h00_00 : div_ff + 8'h00_01;
	assign nxt_step_en = (div_ff == STEP_LAST);
	assign nxt_step    = step_en_ff ? step_ff + 7'd1 : step_ff;
	assign period64    = step_en_ff && (step_ff[5:0] == 6'h3F);
	assign period128   = step_en_ff && (step_ff == 7'h7F);

	// divider and step counter
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			div_ff     <= 8'h00_00;
			step_en_ff <= 1'b0;
			step_ff    <= 7'h00;
			frame_ff   <= 7'h00;
		end
		else
		begin
			div_ff     <= nxt_div;
			step_en_ff <= nxt_step_en;
			step_ff    <= nxt_step;
			if (period128)
				frame_ff <= frame_ff + 7'd1;
		end
	end

	// write strobes per register
	assign wr_low  = sfr_wr_in && (sfr_addr_in == TVP_ADDR_FINE_LOW);
	assign wr_high = sfr_wr_in && (sfr_addr_in == TVP_ADDR_FINE_HIGH);

	// eight duty channels with their registers
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_chan
			assign wr_duty[gi] = sfr_wr_in && (sfr_addr_in == DUTY_ADDR[gi]);
			// control register: takeover bit and duty value
			always_ff @(posedge core_clk_in)
			begin
				if (rst_in)
					duty_reg_ff[gi] <= TVP_DUTY_RST;
				else if (wr_duty[gi])
					duty_reg_ff[gi] <= sfr_wdata_in;
			end
			tvp_duty_chan u_chan (
				.core_clk_in     (core_clk_in),
				.rst_in          (rst_in),
				.period_start_in (period64),
				.step_in         (step_ff[5:0]),
				.duty_in         (duty_reg_ff[gi][5:0]),
				.pwm_out         (chan_pwm[gi])
			);
		end
	endgenerate

	// fine dac registers; active value loaded on high byte write
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			fine_low_ff  <= TVP_FINE_RST;
			fine_high_ff <= TVP_FINE_RST;
			fine_act_ff  <= 14'h0000;
			fine_en_ff   <= 1'b0;
		end
		else
		begin
			if (wr_low)
				fine_low_ff <= sfr_wdata_in;
			if (wr_high)
				fine_high_ff <= sfr_wdata_in;
			if (wr_high)
				fine_act_ff <= {sfr_wdata_in[5:0], fine_low_ff};
			if (wr_high)
				fine_en_ff <= sfr_wdata_in[TVP_TAKEOVER_BIT];
		end
	end

	// fine pwm: base width plus spread extension step
	assign base_w    = fine_act_ff[13:7];
	assign ext_n     = fine_act_ff[6:0];
	assign rev_frame = {frame_ff[0], frame_ff[1], frame_ff[2], frame_ff[3],
		frame_ff[4], frame_ff[5], frame_ff[6]};
	assign ext_now   = (rev_frame < ext_n);
	assign nxt_fine_pwm = (step_ff < base_w) ||
		(ext_now && (step_ff == base_w));

	// pin multiplex between pwm and port latch
	assign nxt_p2 = {duty_reg_ff[6][7] ? chan_pwm[6] : port2_latch_in[7],
		duty_reg_ff[5][7] ? chan_pwm[5] : port2_latch_in[6],
		duty_reg_ff[4][7] ? chan_pwm[4] : port2_latch_in[5],
		duty_reg_ff[3][7] ? chan_pwm[3] : port2_latch_in[4],
		duty_reg_ff[2][7] ? chan_pwm[2] : port2_latch_in[3],
		duty_reg_ff[1][7] ? chan_pwm[1] : port2_latch_in[2],
		duty_reg_ff[0][7] ? chan_pwm[0] : port2_latch_in[1],
		fine_en_ff ? fine_pwm_ff : port2_latch_in[0]};
	assign nxt_p34 = duty_reg_ff[7][7] ? chan_pwm[7] : port3_bit4_latch_in;

	// register read mux, unused bit six reads zero
	always_comb
	begin
		duty_sel = 8'h00_00;
		duty_hit = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (sfr_addr_in == DUTY_ADDR[i])
			begin
				duty_sel = duty_reg_ff[i] & 8'h00_BF;
				duty_hit = 1'b1;
			end
		end
	end
	assign nxt_rdata = !sfr_rd_in ? rdata_ff :
		(sfr_addr_in == TVP_ADDR_FINE_LOW) ? fine_low_ff :
		(sfr_addr_in == TVP_ADDR_FINE_HIGH) ? (fine_high_ff & 8'h00_BF) :
		duty_hit ? duty_sel : 8'h00_00;

	// registered outputs
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			fine_pwm_ff <= 1'b0;
			p2_ff       <= 8'h00_FF;
			p34_ff      <= 1'b1;
			rdata_ff    <= 8'h00_00;
		end
		else
		begin
			fine_pwm_ff <= nxt_fine_pwm;
			p2_ff       <= nxt_p2;
			p34_ff      <= nxt_p34;
			rdata_ff    <= nxt_rdata;
		end
	end

	assign port2_pin_out      = p2_ff;
	assign port3_bit4_pin_out = p34_ff;
	assign sfr_rdata_out      = rdata_ff;

	// checks
	property p_step_period;
		@(posedge core_clk_in) disable iff (rst_in)
		step_en_ff |=> !step_en_ff [*2];
	endproperty
	a_step_period: assert property (p_step_period)
		else $error("step enable too frequent");

	property p_hi_load;
		@(posedge core_clk_in) disable iff (rst_in)
		wr_high |=> fine_act_ff == {$past(sfr_wdata_in[5:0]), $past(fine_low_ff)};
	endproperty
	a_hi_load: assert property (p_hi_load)
		else $error("fine value not loaded on high write");

	property p_low_hold;
		@(posedge core_clk_in) disable iff (rst_in)
		(wr_low && !wr_high) |=> $stable(fine_act_ff);
	endproperty
	a_low_hold: assert property (p_low_hold)
		else $error("low write changed active value");

	property p_port_follow;
		@(posedge core_clk_in) disable iff (rst_in)
		!duty_reg_ff[0][7] |=> port2_pin_out[1] == $past(port2_latch_in[1]);
	endproperty
	a_port_follow: assert property (p_port_follow)
		else $error("port pin not following latch");

	property p_pwm_drive;
		@(posedge core_clk_in) disable iff (rst_in)
		duty_reg_ff[7][7] |=> port3_bit4_pin_out == $past(chan_pwm[7]);
	endproperty
	a_pwm_drive: assert property (p_pwm_drive)
		else $error("pwm not driving port3 bit4");

	property p_fine_pin;
		@(posedge core_clk_in) disable iff (rst_in)
		fine_en_ff |=> port2_pin_out[0] == $past(fine_pwm_ff);
	endproperty
	a_fine_pin: assert property (p_fine_pin)
		else $error("fine pwm not on port2 bit0");

	property p_fine_zero;
		@(posedge core_clk_in) disable iff (rst_in)
		(fine_act_ff == 14'h0000) |=> !fine_pwm_ff;
	endproperty
	a_fine_zero: assert property (p_fine_zero)
		else $error("zero value gave a pulse");

	property p_fine_base;
		@(posedge core_clk_in) disable iff (rst_in)
		(step_ff < base_w) |=> fine_pwm_ff;
	endproperty
	a_fine_base: assert property (p_fine_base)
		else $error("fine pulse low inside base width");
endmodule
`default_nettype wire

// ===== tvp_pkg.sv
// constants for the television pwm dac bank
package tvp_pkg;
	// special function register addresses
	localparam logic [7:0] TVP_ADDR_FINE_LOW  = 8'h00_D2;
	localparam logic [7:0] TVP_ADDR_FINE_HIGH = 8'h00_D3;
	localparam logic [7:0] TVP_ADDR_DUTY0     = 8'h00_D5;
	localparam logic [7:0] TVP_ADDR_DUTY1     = 8'h00_D6;
	localparam logic [7:0] TVP_ADDR_DUTY2     = 8'h00_D7;
	localparam logic [7:0] TVP_ADDR_DUTY3     = 8'h00_DC;
	localparam logic [7:0] TVP_ADDR_DUTY4     = 8'h00_DD;
	localparam logic [7:0] TVP_ADDR_DUTY5     = 8'h00_DE;
	localparam logic [7:0] TVP_ADDR_DUTY6     = 8'h00_DF;
	localparam logic [7:0] TVP_ADDR_DUTY7     = 8'h00_E4;
	// field positions
	localparam int TVP_TAKEOVER_BIT = 7;
	localparam int TVP_COARSE_LSB_BIT = 7;
	// reset values
	localparam logic [7:0] TVP_DUTY_RST = 8'h00_40;
	localparam logic [7:0] TVP_FINE_RST = 8'h00_00;
	// timing: oscillator 12 mhz, one step 0.33 us = four periods
	localparam int TVP_OSC_KHZ       = 12000;
	localparam int TVP_STEP_OSC      = 4;
	localparam int TVP_CORE_KHZ      = 200000;
	localparam int TVP_DUTY_STEPS    = 64;
	localparam int TVP_FINE_STEPS    = 128;
	localparam int TVP_FINE_CYCLES   = 128;
endpackage

// ===== tvp_duty_chan.sv
// one six bit pwm channel with period-aligned duty reload
`timescale 1ns/1ps
`default_nettype none
module tvp_duty_chan
	import tvp_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       rst_in,
	input  wire logic       period_start_in,
	input  wire logic [5:0] step_in,
	input  wire logic [5:0] duty_in,
	output logic            pwm_out
);
	logic [5:0] duty_ff;
	logic       pwm_ff;
	logic [5:0] nxt_duty;
	logic       nxt_pwm;

	// duty latched only at period start, high while step below duty
	assign nxt_duty = period_start_in ? duty_in : duty_ff;
	assign nxt_pwm  = (step_in < nxt_duty);
	assign pwm_out  = pwm_ff;

	// hold active duty and the output bit
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			duty_ff <= TVP_DUTY_RST[5:0];
			pwm_ff  <= 1'b0;
		end
		else
		begin
			duty_ff <= nxt_duty;
			pwm_ff  <= nxt_pwm;
		end
	end
endmodule
`default_nettype wire

// ===== tvp_pwm_bank_bench.sv
// self-checking testbench for the pwm dac bank
`timescale 1ns/1ps
`default_nettype none
module tvp_pwm_bank_bench;
	import tvp_pkg::*;
	// divider runs at oscillator rate so one step is four clocks
	localparam int STEP = TVP_STEP_OSC;
	localparam int PER  = TVP_DUTY_STEPS * STEP;
	localparam int FPER = TVP_FINE_STEPS * STEP;
	logic       core_clk_in         = 1'b0;
	logic       rst_in              = 1'b1;
	logic [7:0] sfr_addr_in         = 8'h00_00;
	logic [7:0] sfr_wdata_in        = 8'h00_00;
	logic       sfr_wr_in           = 1'b0;
	logic       sfr_rd_in           = 1'b0;
	logic [7:0] port2_latch_in      = 8'h00_FF;
	logic       port3_bit4_latch_in = 1'b1;
	logic [7:0] sfr_rdata_out;
	logic [7:0] port2_pin_out;
	logic       port3_bit4_pin_out;
	int         fails      = 0;
	int         num_checks = 0;
	int         seed       = 10;
	int         hi [9];
	logic [7:0] duty_addr [8] = '{TVP_ADDR_DUTY0, TVP_ADDR_DUTY1,
		TVP_ADDR_DUTY2, TVP_ADDR_DUTY3, TVP_ADDR_DUTY4, TVP_ADDR_DUTY5,
		TVP_ADDR_DUTY6, TVP_ADDR_DUTY7};
	logic [7:0] d;
	logic [5:0] c;
	logic [6:0] e;
	int         w;

	// 200 mhz clock
	always #2.5 core_clk_in = ~core_clk_in;

	tvp_pwm_bank #(.CORE_KHZ(TVP_OSC_KHZ)) dut (
		.core_clk_in        (core_clk_in),
		.rst_in             (rst_in),
		.sfr_addr_in        (sfr_addr_in),
		.sfr_wdata_in       (sfr_wdata_in),
		.sfr_wr_in          (sfr_wr_in),
		.sfr_rd_in          (sfr_rd_in),
		.sfr_rdata_out      (sfr_rdata_out),
		.port2_latch_in     (port2_latch_in),
		.port3_bit4_latch_in(port3_bit4_latch_in),
		.port2_pin_out      (port2_pin_out),
		.port3_bit4_pin_out (port3_bit4_pin_out)
	);

	// compare and count
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// one-cycle write strobe, driven on the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge core_clk_in);
		sfr_addr_in = a;
		sfr_wdata_in = v;
		sfr_wr_in = 1'b1;
		@(negedge core_clk_in);
		sfr_wr_in = 1'b0;
	endtask

	// read strobe, then sample the registered data a cycle later
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge core_clk_in);
		sfr_addr_in = a;
		sfr_rd_in = 1'b1;
		@(negedge core_clk_in);
		sfr_rd_in = 1'b0;
		@(negedge core_clk_in);
		chk("rdata", {24'h0, exp}, {24'h0, sfr_rdata_out});
	endtask

	// count high cycles of every pwm pin over n clocks
	task automatic measure(input int n);
		for (int i = 0; i < 9; i++) hi[i] = 0;
		repeat (n)
		begin
			@(negedge core_clk_in);
			for (int i = 0; i < 8; i++) hi[i] += (port2_pin_out[i] === 1'b1);
			hi[8] += (port3_bit4_pin_out === 1'b1);
		end
	endtask

	// print counts and verdict, end the run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// watchdog against a hang
	initial
	begin
		repeat (90000) @(posedge core_clk_in);
		fails++;
		give_verdict();
	end

	// main sequence
	initial
	begin
		repeat (5) @(negedge core_clk_in);
		rst_in = 1'b0;
		// register write and read back, unused bit six reads zero
		for (int i = 0; i < 8; i++)
		begin
			d = 8'($random(seed));
			wr(duty_addr[i], d);
			rd_chk(duty_addr[i], d & 8'h00_BF);
		end
		d = 8'($random(seed));
		wr(TVP_ADDR_FINE_LOW, d);
		rd_chk(TVP_ADDR_FINE_LOW, d);
		wr(TVP_ADDR_FINE_HIGH, d);
		rd_chk(TVP_ADDR_FINE_HIGH, d & 8'h00_BF);
		wr(8'h00_D4, 8'h00_FF);
		rd_chk(8'h00_D4, 8'h00_00);
		// duty rounds: corners 0..63 first, then random values
		for (int r = 0; r < 4; r++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				d = (r == 0) ? 8'(i * 9) : 8'($random(seed) & 63);
				duty_addr_val[i] = d;
				wr(duty_addr[i], 8'h00_80 | d);
			end
			repeat (2 * PER) @(negedge core_clk_in);
			measure(2 * PER);
			for (int i = 0; i < 8; i++)
				chk("duty high", 2 * STEP * duty_addr_val[i], hi[i + 1]);
		end
		// takeover off: pins follow the latch
		for (int i = 0; i < 8; i++) wr(duty_addr[i], 8'h00_3F);
		wr(TVP_ADDR_FINE_HIGH, 8'h00_3F);
		repeat (4)
		begin
			port2_latch_in = 8'($random(seed));
			port3_bit4_latch_in = 1'($random(seed));
			repeat (2) @(negedge core_clk_in);
			chk("port2 pins", port2_latch_in, port2_pin_out);
			chk("port3 pin", port3_bit4_latch_in, port3_bit4_pin_out);
		end
		// latch bits high so the pwm can own the pins
		port2_latch_in = 8'h00_FF;
		port3_bit4_latch_in = 1'b1;
		// fine pwm base width from the upper seven bits
		c = 6'($unsigned($random(seed)) % 62);
		w = 2 * c;
		wr(TVP_ADDR_FINE_LOW, 8'h00_00);
		wr(TVP_ADDR_FINE_HIGH, 8'h00_80 | c);
		repeat (2 * FPER) @(negedge core_clk_in);
		measure(FPER);
		chk("fine high", w * STEP, hi[0]);
		// low byte alone changes nothing
		wr(TVP_ADDR_FINE_LOW, 8'h00_80);
		repeat (2 * FPER) @(negedge core_clk_in);
		measure(FPER);
		chk("fine held", w * STEP, hi[0]);
		wr(TVP_ADDR_FINE_HIGH, 8'h00_80 | c);
		repeat (2 * FPER) @(negedge core_clk_in);
		measure(FPER);
		chk("fine lsb", (w + 1) * STEP, hi[0]);
		// extension spread over 128 frames
		e = 7'($random(seed)) | 7'h01;
		wr(TVP_ADDR_FINE_LOW, {1'b1, e});
		wr(TVP_ADDR_FINE_HIGH, 8'h00_80 | c);
		repeat (2 * FPER) @(negedge core_clk_in);
		measure(TVP_FINE_CYCLES * FPER);
		chk("fine ext", (128 * (w + 1) + e) * STEP, hi[0]);
		give_verdict();
	end

	int duty_addr_val [8];
endmodule
`default_nettype wire
